/* File: rtl/scc_pkg.sv */
// constants and carrier types for the solenoid current controller
package scc_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int WORD_BITS     = 16;
  localparam int CNT_W         = 5;
  // command word layout
  localparam logic [3:0] DRIVER_ADDR = 4'hb;
  localparam int ADDR_LSB    = 12;
  localparam int DIAG_BIT    = 11;
  localparam int DTHR_BIT    = 10;
  localparam int SEL_BIT     = 9;
  localparam int REGDIS_BIT  = 8;
  localparam int ONOFF_BIT   = 7;
  localparam int AMP_LSB     = 4;
  localparam int FREQ_LSB    = 0;
  localparam int DAC_LSB     = 0;
  // current scaling in microamps
  localparam int UA_W          = 21;
  localparam int FULL_SCALE_UA = 1_075_000;
  localparam int DAC_MAX       = 511;
  localparam int LSB_UA        = FULL_SCALE_UA / DAC_MAX;
  localparam int AMP_STEP_UA   = 50_400;
  localparam int HYST_DIV      = 20;
  // dither codes
  localparam logic [3:0] FREQ_OFF  = 4'h0;
  localparam logic [3:0] FREQ_KEEP = 4'hf;
  localparam logic [2:0] AMP_OFF   = 3'h0;
  // pin order {sclk, cs_n, mosi} and idle levels
  localparam logic [2:0] PIN_IDLE  = 3'h2;

  typedef struct packed {
    logic       diag_pullup_select;
    logic       dither_off_bit;
    logic [8:0] dac;
  } scc_setpoint_t;

  typedef struct packed {
    logic [2:0] amp;
    logic [3:0] freq;
  } scc_dither_t;

  localparam scc_setpoint_t SETPOINT_RST = '0;
  localparam scc_dither_t   DITHER_RST   = '0;

  typedef enum logic [1:0] {
    REG_DECAY = 2'b01,
    REG_RISE  = 2'b10
  } scc_reg_state_t;
endpackage

/* File: rtl/scc_current_ctrl.sv */
// hysteretic solenoid current controller with dither, driven by spi command words
`timescale 1ns/1ns
// What this block does
// - setpoint commands average current from zero up to 1075mA without dither
// - setpoint plus amplitude at or above 1075mA suppresses dither
// - setpoint minus amplitude at or below zero suppresses dither
// - control word holds address, pull-up select, dither off, 9-bit setpoint
// - driver off until lower point, then on until upper point, repeating
// - switch points sit at plus and minus 5 percent of target
// - dither alternately raises and lowers setpoint at programmed rate
// - new amplitude or frequency applies at start of next positive half
// - regulation disable bit makes output follow plain on/off bit
// - on/off bit 1 switches output on, 0 switches it off
// - fault shutdown acts the same in both modes
// - diagnostic bit 0 selects pull-down, 1 selects pull-up source
// - dither off bit stops dither whatever amplitude and frequency
// - frequency code 0 is off, 1 onward fixed rates, 15 no change
// - amplitude code 0 is off, each step adds 50.4mA
module scc_current_ctrl
  import scc_pkg::*;
#(
  parameter int CLK_HZ_P = CLK_HZ
) (
  input  wire logic            clk,              // 50 MHz clock
  input  wire logic            reset_n,          // async reset, active low
  input  wire logic            spi_sclk,         // spi clock pin
  input  wire logic            spi_cs_n,         // spi chip select pin, active low
  input  wire logic            spi_mosi,         // spi data in pin
  input  wire logic [UA_W-1:0] sense_current_ua, // measured load current
  input  wire logic            fault_shutdown,   // protection demands output off
  output logic                 drive_on,         // low-side driver gate
  output logic                 diag_pullup_en,   // diagnostic pull-up source
  output logic                 diag_pulldown_en, // diagnostic pull-down source
  output logic                 dither_active,    // dither applied to target
  output logic [UA_W-1:0]      target_ua         // current target after dither
);
  localparam int HALF_W = $clog2(CLK_HZ_P / 100 + 1);

  if (CLK_HZ_P < 1064) begin : g_bad_clk
    $error("clock too slow for dither rates");
  end

  function automatic logic [HALF_W-1:0] half_len(input logic [3:0] code);
    case (code)
      4'h1:    return HALF_W'(CLK_HZ_P / 100);
      4'h2:    return HALF_W'(CLK_HZ_P / 200);
      4'h3:    return HALF_W'(CLK_HZ_P / 300);
      4'h4:    return HALF_W'(CLK_HZ_P / 400);
      4'h5:    return HALF_W'(CLK_HZ_P / 500);
      4'h6:    return HALF_W'(CLK_HZ_P / 600);
      4'h7:    return HALF_W'(CLK_HZ_P / 700);
      4'h8:    return HALF_W'(CLK_HZ_P / 800);
      4'h9:    return HALF_W'(CLK_HZ_P / 900);
      4'ha:    return HALF_W'(CLK_HZ_P / 1000);
      4'hb:    return HALF_W'(CLK_HZ_P / 266);
      4'hc:    return HALF_W'(CLK_HZ_P / 332);
      4'hd:    return HALF_W'(CLK_HZ_P / 466);
      4'he:    return HALF_W'(CLK_HZ_P / 532);
      default: return HALF_W'(1);
    endcase
  endfunction

  // pin synchronisers, three stages
  logic [2:0] pin_s1, pin_s2, pin_s3, pin_f, pin_d;
  wire  [2:0] pin_raw    = {spi_sclk, spi_cs_n, spi_mosi};
  wire  [2:0] pin_differ = pin_s2 ^ pin_s3;
  wire  [2:0] next_pin_f = (pin_s2 & ~pin_differ) | (pin_f & pin_differ);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
      pin_f  <= PIN_IDLE;
      pin_d  <= PIN_IDLE;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= next_pin_f;
      pin_d  <= pin_f;
    end
  end

  wire sclk_rise = pin_f[2] & ~pin_d[2];
  wire cs_rise   = pin_f[1] & ~pin_d[1];
  wire cs_low    = ~pin_f[1];

  // word shifter, mode 0, msb first
  logic [WORD_BITS-1:0] shift;
  logic [CNT_W-1:0]     bit_cnt;
  wire word_done = cs_rise && (bit_cnt == CNT_W'(WORD_BITS));
  wire addr_hit  = shift[ADDR_LSB +: 4] == DRIVER_ADDR;
  wire wr_setpt  = word_done && addr_hit && !shift[SEL_BIT];
  wire wr_dither = word_done && addr_hit && shift[SEL_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift   <= '0;
      bit_cnt <= '0;
    end else if (!cs_low) begin
      bit_cnt <= '0;
    end else if (sclk_rise) begin
      shift   <= {shift[WORD_BITS-2:0], pin_f[0]};
      bit_cnt <= (bit_cnt > CNT_W'(WORD_BITS)) ? bit_cnt : bit_cnt + CNT_W'(1);
    end
  end

  // command registers
  scc_setpoint_t setpt;
  scc_dither_t   pend, applied;
  logic          reg_dis, onoff;
  wire [3:0] new_freq = (shift[FREQ_LSB +: 4] == FREQ_KEEP) ? pend.freq
                                                          : shift[FREQ_LSB +: 4];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      setpt   <= SETPOINT_RST;
      pend    <= DITHER_RST;
      reg_dis <= 1'b0;
      onoff   <= 1'b0;
    end else if (wr_setpt) begin
      setpt <= '{shift[DIAG_BIT], shift[DTHR_BIT], shift[DAC_LSB +: 9]};
    end else if (wr_dither) begin
      pend    <= '{shift[AMP_LSB +: 3], new_freq};
      reg_dis <= shift[REGDIS_BIT];
      onoff   <= shift[ONOFF_BIT];
    end
  end

  // dither half-cycle timing
  logic [HALF_W-1:0] half_cnt;
  logic              phase_pos;
  wire dither_run = (applied.freq != FREQ_OFF) && (applied.amp != AMP_OFF);
  wire half_end   = half_cnt >= half_len(applied.freq) - HALF_W'(1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      applied   <= DITHER_RST;
      half_cnt  <= '0;
      phase_pos <= 1'b1;
    end else if (!dither_run) begin
      applied   <= pend;
      half_cnt  <= '0;
      phase_pos <= 1'b1;
    end else if (half_end) begin
      half_cnt  <= '0;
      phase_pos <= ~phase_pos;
      if (!phase_pos) begin
        applied <= pend;
      end
    end else begin
      half_cnt <= half_cnt + HALF_W'(1);
    end
  end

  // target and dither lockout
  wire [UA_W-1:0] dac_ua  = UA_W'(setpt.dac * LSB_UA);
  wire [UA_W-1:0] amp_ua  = UA_W'(applied.amp * AMP_STEP_UA);
  wire [UA_W:0]   sum_ua  = {1'b0, dac_ua} + {1'b0, amp_ua};
  wire            lock_hi = sum_ua >= (UA_W+1)'(FULL_SCALE_UA);
  wire            lock_lo = dac_ua <= amp_ua;
  wire next_dither = dither_run && !setpt.dither_off_bit && !lock_hi && !lock_lo;
  wire [UA_W-1:0] next_target = !next_dither ? dac_ua
                              : phase_pos    ? UA_W'(sum_ua)
                              : dac_ua - amp_ua;

  // hysteretic switch points
  wire [UA_W-1:0] band   = target_ua / UA_W'(HYST_DIV);
  wire [UA_W:0]   upper  = {1'b0, target_ua} + {1'b0, band};
  wire [UA_W-1:0] lower  = target_ua - band;
  wire            at_low = (sense_current_ua <= lower) && (target_ua != '0);
  wire            at_up  = {1'b0, sense_current_ua} >= upper;

  scc_reg_state_t state, next_state;
  always_comb begin
    case (state)
      REG_DECAY: next_state = at_low ? REG_RISE : REG_DECAY;
      REG_RISE:  next_state = at_up ? REG_DECAY : REG_RISE;
      default:   next_state = REG_DECAY;
    endcase
  end

  wire next_drive = !fault_shutdown && (reg_dis ? onoff : (state == REG_RISE));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state            <= REG_DECAY;
      target_ua        <= '0;
      dither_active    <= 1'b0;
      drive_on         <= 1'b0;
      diag_pullup_en   <= 1'b0;
      diag_pulldown_en <= 1'b1;
    end else begin
      state            <= next_state;
      target_ua        <= next_target;
      dither_active    <= next_dither;
      drive_on         <= next_drive;
      diag_pullup_en   <= setpt.diag_pullup_select;
      diag_pulldown_en <= !setpt.diag_pullup_select;
    end
  end

  // checks
  sequence s_word_end;
    cs_rise && bit_cnt == CNT_W'(WORD_BITS) && addr_hit && !shift[SEL_BIT];
  endsequence
  sequence s_short_word;
    cs_rise && bit_cnt != CNT_W'(WORD_BITS);
  endsequence

  chk_full_word: assert property (@(posedge clk) disable iff (!reset_n)
    s_short_word |=> $stable(setpt) && $stable(pend)) else $error("partial word acted on");
  chk_setpt_load: assert property (@(posedge clk) disable iff (!reset_n)
    s_word_end |=> setpt.dac == $past(shift[8:0])) else $error("setpoint not loaded");
  chk_other_addr: assert property (@(posedge clk) disable iff (!reset_n)
    word_done && !addr_hit |=> $stable(setpt) && $stable(pend)) else $error("foreign word taken");
  chk_lock_high: assert property (@(posedge clk) disable iff (!reset_n)
    lock_hi |=> !dither_active && target_ua == $past(dac_ua)) else $error("high lockout missed");
  chk_lock_low: assert property (@(posedge clk) disable iff (!reset_n)
    lock_lo |=> !dither_active) else $error("low lockout missed");
  chk_dither_off: assert property (@(posedge clk) disable iff (!reset_n)
    setpt.dither_off_bit |=> target_ua == $past(dac_ua)) else $error("dither not stopped");
  chk_half_toggle: assert property (@(posedge clk) disable iff (!reset_n)
    dither_run && half_end |=> phase_pos != $past(phase_pos)) else $error("phase missed");
  chk_apply_pos: assert property (@(posedge clk) disable iff (!reset_n)
    dither_run && !(half_end && !phase_pos) |=> applied == $past(applied))
    else $error("dither update early");
  chk_rise_stop: assert property (@(posedge clk) disable iff (!reset_n)
    state == REG_RISE && at_up |=> state == REG_DECAY ##1 !drive_on || reg_dis)
    else $error("upper point ignored");
  chk_decay_stop: assert property (@(posedge clk) disable iff (!reset_n)
    state == REG_DECAY && at_low |=> state == REG_RISE) else $error("lower point ignored");
  chk_onoff_mode: assert property (@(posedge clk) disable iff (!reset_n)
    reg_dis && !fault_shutdown |=> drive_on == $past(onoff)) else $error("on/off not followed");
  chk_fault_off: assert property (@(posedge clk) disable iff (!reset_n)
    fault_shutdown |=> !drive_on) else $error("fault did not stop drive");
  chk_diag_sel: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 diag_pullup_en == $past(setpt.diag_pullup_select) && diag_pulldown_en != diag_pullup_en)
    else $error("diag select wrong");
endmodule

/* File: bench/scc_spi_host.sv */
// spi host model sending command words to the controller
`timescale 1ns/1ns
module scc_spi_host (
  input  wire logic clk,  // bench clock
  output logic      sclk, // spi clock, idle low
  output logic      cs_n, // chip select, active low
  output logic      mosi  // serial data, msb first
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // n below 16 makes a short word on purpose
  task automatic send(input logic [15:0] w, input int n);
    int i;
    @(posedge clk) cs_n <= 1'b0;
    for (i = 0; i < n; i++) begin
      mosi <= w[15-i];
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi; // released line shows no stale bit
    repeat (12) @(posedge clk);
  endtask
endmodule

/* File: bench/scc_current_ctrl_tb_top.sv */
// self-checking bench for the solenoid current controller
`timescale 1ns/1ns
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", what, exp, got); end end
module scc_current_ctrl_tb_top;
  import scc_pkg::*;
  logic            clk = 1'b0;
  logic            reset_n = 1'b0;
  logic [UA_W-1:0] sense = '0;
  logic            fault = 1'b0;
  logic            sclk, cs_n, mosi, drive_on, pu, pd, dact;
  logic [UA_W-1:0] target;
  int              fails = 0;
  int              num_checks = 0;
  localparam int   T = 238 * LSB_UA;
  localparam int   A = AMP_STEP_UA;

  always #10 clk = ~clk;

  scc_spi_host i_scc_spi_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  scc_current_ctrl #(.CLK_HZ_P(10000)) i_scc_current_ctrl (
    .clk(clk), .reset_n(reset_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .sense_current_ua(sense), .fault_shutdown(fault), .drive_on(drive_on),
    .diag_pullup_en(pu), .diag_pulldown_en(pd), .dither_active(dact), .target_ua(target));

  task automatic ctl(input logic d, input logic off, input logic [8:0] dac);
    i_scc_spi_host.send({DRIVER_ADDR, d, off, 1'b0, dac}, 16);
  endtask
  task automatic dth(input logic dis, input logic on, input logic [2:0] a, input logic [3:0] f);
    i_scc_spi_host.send({DRIVER_ADDR, 2'b00, 1'b1, dis, on, a, f}, 16);
  endtask
  task automatic set_in(input int s, input logic f);
    sense <= UA_W'(s);
    fault <= f;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_setpoint();
    `CHK("pulldown at reset", 1'b1, pd)
    ctl(1'b1, 1'b0, 9'd238);
    `CHK("target", UA_W'(T), target)
    `CHK("pullup", 1'b1, pu)
    `CHK("pulldown", 1'b0, pd)
  endtask
  task automatic t_regulate();
    set_in(T + T / 20 - 1, 1'b0);
    `CHK("on below upper", 1'b1, drive_on)
    set_in(T + T / 20, 1'b0);
    `CHK("off at upper", 1'b0, drive_on)
    set_in(T - T / 20 + 1, 1'b0);
    `CHK("off above lower", 1'b0, drive_on)
    set_in(T - T / 20, 1'b0);
    `CHK("on at lower", 1'b1, drive_on)
    set_in(T - T / 20, 1'b1);
    `CHK("fault off", 1'b0, drive_on)
    set_in(T, 1'b0);
  endtask
  task automatic t_dither();
    dth(1'b0, 1'b0, 3'd1, 4'd1);
    `CHK("dither on", 1'b1, dact)
    `CHK("positive half", UA_W'(T + A), target)
    repeat (100) @(posedge clk);
    `CHK("negative half", UA_W'(T - A), target)
    ctl(1'b0, 1'b0, 9'd511);
    `CHK("high lockout", 1'b0, dact)
    `CHK("high target", UA_W'(511 * LSB_UA), target)
    ctl(1'b0, 1'b0, 9'd10);
    `CHK("low lockout", 1'b0, dact)
    ctl(1'b0, 1'b1, 9'd238);
    `CHK("dither off bit", 1'b0, dact)
    `CHK("plain target", UA_W'(T), target)
    dth(1'b0, 1'b0, 3'd1, FREQ_OFF);
    dth(1'b0, 1'b0, 3'd1, FREQ_KEEP);
    ctl(1'b0, 1'b0, 9'd238);
    `CHK("freq off kept", 1'b0, dact)
    `CHK("pullup cleared", 1'b0, pu)
  endtask
  task automatic t_refused();
    i_scc_spi_host.send({4'ha, 3'b100, 9'd101}, 16);
    `CHK("other address", UA_W'(T), target)
    `CHK("other address diag", 1'b0, pu)
    // odd word above leaves a 1 behind, so these 15 bits would decode as addressed
    i_scc_spi_host.send({3'b011, 3'b100, 9'd100, 1'b0}, 15);
    `CHK("short word", UA_W'(T), target)
    `CHK("short word diag", 1'b0, pu)
  endtask
  task automatic t_onoff();
    set_in(T + T, 1'b0);
    dth(1'b1, 1'b1, AMP_OFF, FREQ_OFF);
    `CHK("on/off on", 1'b1, drive_on)
    set_in(T + T, 1'b1);
    `CHK("on/off fault", 1'b0, drive_on)
    set_in(0, 1'b0);
    dth(1'b1, 1'b0, AMP_OFF, FREQ_OFF);
    `CHK("on/off off", 1'b0, drive_on)
  endtask

  task automatic report_and_stop();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_setpoint();
    t_regulate();
    t_dither();
    t_refused();
    t_onoff();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule
